// File: src/rtr_defs.svh
// register indices, field positions and reset values of the remap block
`ifndef RTR_DEFS_SVH
`define RTR_DEFS_SVH

// register indices; byte address is four times the index
`define RTR_IDX_TGT1 8'h70
`define RTR_IDX_TGT2 8'h71
`define RTR_IDX_TGT3 8'h72
`define RTR_IDX_TGT4 8'h73
`define RTR_IDX_TGT5 8'h74
`define RTR_IDX_TGT6 8'h75
`define RTR_IDX_ALIAS1 8'h77
`define RTR_IDX_CTRL 8'h7E
`define RTR_IDX_STATUS 8'h7F

// field positions
`define RTR_ADDR_MSB 7
`define RTR_ADDR_LSB 1
`define RTR_CTRL_PORT_SEL 0

// reset values
`define RTR_TGT_RESET 7'h00
`define RTR_ALIAS_RESET 7'h00

`endif

// File: src/rtr_pkg.sv
// types shared by the target remap block
package rtr_pkg;

    // apb answer sequencer
    typedef enum logic [0:0] {
        RTR_IDLE = 1'b0,
        RTR_ANSWER = 1'b1
    } rtr_apb_state_t;

    typedef logic [6:0] rtr_addr7_t;

endpackage

// File: src/rtr_tbl_mem.sv
// table of real remote target addresses, one write and two read ports
`timescale 1ns/10ps
`include "rtr_defs.svh"

module rtr_tbl_mem #(
    parameter int DEPTH = 12,
    parameter int WIDTH = 7,
    parameter int AW = 4
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // write port
    input wire logic wr_en,
    input wire logic [AW-1:0] wr_idx,
    input wire logic [WIDTH-1:0] wr_data,
    // read ports, data one cycle after the index
    input wire logic [AW-1:0] rd_a_idx,
    output logic [WIDTH-1:0] rd_a_data,
    input wire logic [AW-1:0] rd_b_idx,
    output logic [WIDTH-1:0] rd_b_data
);

    typedef struct packed {
        logic [DEPTH-1:0][WIDTH-1:0] mem;
        logic [WIDTH-1:0] a;
        logic [WIDTH-1:0] b;
    } rtr_mem_state_t;

    rtr_mem_state_t s;
    rtr_mem_state_t next_s;

    if (DEPTH > (1 << AW)) begin : g_chk
        $error("rtr_tbl_mem: DEPTH does not fit AW");
    end

    // read data registered; a write in the same cycle is seen next read
    always_comb begin
        next_s = s;
        next_s.a = (int'(rd_a_idx) < DEPTH) ? s.mem[rd_a_idx] : '0;
        next_s.b = (int'(rd_b_idx) < DEPTH) ? s.mem[rd_b_idx] : '0;
        if (wr_en && int'(wr_idx) < DEPTH) begin
            next_s.mem[wr_idx] = wr_data;
        end
    end

    // every entry clears so each target starts out blocked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    assign rd_a_data = s.a;
    assign rd_b_data = s.b;

endmodule

// File: src/rtr_remap.sv
// remote target id remap: apb registers and alias-to-address lookup
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/10ps
`include "rtr_defs.svh"

module rtr_remap #(
    parameter int ADDR_W = 12,
    parameter int NUM_TARGETS = 6
) (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [ADDR_W-1:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // lookup request from the local i2c target logic
    input wire logic lookup_valid,
    input wire logic [6:0] lookup_addr,
    input wire logic lookup_port,
    // lookup answer toward the control channel
    output logic fwd_valid,
    output logic fwd_block,
    output logic [6:0] fwd_addr
);

    localparam int TBL_DEPTH = 2 * NUM_TARGETS;

    typedef struct packed {
        rtr_pkg::rtr_apb_state_t st;
        logic port_sel;
        logic [1:0][NUM_TARGETS-1:0][6:0] alias_tab;
        logic [31:0] rdata;
        logic look;
        logic hit;
        logic [6:0] last_addr;
        logic last_fwd;
        logic last_block;
        logic [2:0] last_slot;
        logic last_port;
    } rtr_state_t;

    rtr_state_t s;
    rtr_state_t next_s;

    logic [6:0] mem_a_data;
    logic [6:0] mem_b_data;
    logic [3:0] mem_a_idx;
    logic [3:0] mem_b_idx;
    logic mem_wr;

    if (NUM_TARGETS != 6 || ADDR_W < 10) begin : g_chk
        $error("rtr_remap: six targets and ADDR_W >= 10 required");
    end

    // flat table index: port 1 copies sit above the port 0 copies
    function automatic logic [3:0] tbl_index(input logic port,
                                             input logic [2:0] slot);
        tbl_index = port ? ({1'b0, slot} + 4'd6) : {1'b0, slot};
    endfunction

    // slot of a register group, or the group size when outside it
    function automatic logic [2:0] slot_of(input logic [7:0] idx,
                                           input logic [7:0] base);
        logic [7:0] d;
        d = idx - base;
        slot_of = (idx >= base && d < 8'(NUM_TARGETS)) ? d[2:0] : 3'd6;
    endfunction

    logic [7:0] reg_idx;
    logic addr_ok;
    logic [2:0] tslot;
    logic [2:0] aslot;
    logic is_tgt;
    logic is_alias;
    logic is_ctrl;
    logic is_stat;
    logic mapped;
    logic answer;

    // address decode, shared by read fetch and write commit
    always_comb begin
        reg_idx = paddr[9:2];
        addr_ok = (paddr[1:0] == 2'b00) && ((paddr >> 10) == '0);
        tslot = slot_of(reg_idx, `RTR_IDX_TGT1);
        aslot = slot_of(reg_idx, `RTR_IDX_ALIAS1);
        is_tgt = addr_ok && (tslot != 3'd6);
        is_alias = addr_ok && (aslot != 3'd6);
        is_ctrl = addr_ok && (reg_idx == `RTR_IDX_CTRL);
        is_stat = addr_ok && (reg_idx == `RTR_IDX_STATUS);
        mapped = is_tgt || is_alias || is_ctrl || is_stat;
        answer = psel && penable && (s.st == rtr_pkg::RTR_ANSWER);
    end

    assign mem_a_idx = tbl_index(s.port_sel, tslot);
    assign mem_wr = answer && pwrite && is_tgt;

    logic match;
    logic [2:0] match_slot;

    // first nonzero alias equal to the incoming address wins
    always_comb begin
        match = 1'b0;
        match_slot = 3'd0;
        for (int i = NUM_TARGETS - 1; i >= 0; i--) begin
            if (s.alias_tab[lookup_port][i] != `RTR_ALIAS_RESET &&
                s.alias_tab[lookup_port][i] == lookup_addr) begin
                match = 1'b1;
                match_slot = 3'(i);
            end
        end
    end

    // the real address is fetched from the table in parallel with the match
    assign mem_b_idx = tbl_index(lookup_port, match_slot);

    // next state: apb sequencer, registers, lookup pipeline
    always_comb begin
        next_s = s;
        next_s.look = lookup_valid;
        next_s.hit = lookup_valid && match;
        unique case (s.st)
            rtr_pkg::RTR_IDLE: begin
                // table read issued during setup is ready in this cycle
                if (psel && penable) begin
                    next_s.st = rtr_pkg::RTR_ANSWER;
                    next_s.rdata = '0;
                    if (is_tgt) begin
                        // address in 7:1, reserved bit 0 reads zero
                        next_s.rdata[`RTR_ADDR_MSB:`RTR_ADDR_LSB] = mem_a_data;
                    end else if (is_alias) begin
                        next_s.rdata[`RTR_ADDR_MSB:`RTR_ADDR_LSB] =
                            s.alias_tab[s.port_sel][aslot];
                    end else if (is_ctrl) begin
                        next_s.rdata[`RTR_CTRL_PORT_SEL] = s.port_sel;
                    end else if (is_stat) begin
                        next_s.rdata[13:0] = {s.last_addr, s.last_port,
                                              s.last_slot, s.last_block,
                                              s.last_fwd, s.look};
                    end
                end
            end
            rtr_pkg::RTR_ANSWER: begin
                next_s.st = rtr_pkg::RTR_IDLE;
                if (answer && pwrite && is_alias) begin
                    // alias write lands in the selected copy
                    next_s.alias_tab[s.port_sel][aslot] =
                        pwdata[`RTR_ADDR_MSB:`RTR_ADDR_LSB];
                end
                if (answer && pwrite && is_ctrl) begin
                    next_s.port_sel = pwdata[`RTR_CTRL_PORT_SEL];
                end
            end
        endcase
        // outcome of the lookup answered this cycle, kept for software
        if (s.look) begin
            next_s.last_fwd = fwd_valid;
            next_s.last_block = fwd_block;
            next_s.last_addr = fwd_valid ? mem_b_data : 7'h00;
        end
        if (lookup_valid) begin
            next_s.last_slot = match_slot;
            next_s.last_port = lookup_port;
        end
    end

    // all control state clears, so every target starts out blocked
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s <= '0;
        end else begin
            s <= next_s;
        end
    end

    rtr_tbl_mem #(
        .DEPTH(TBL_DEPTH),
        .WIDTH(7),
        .AW(4)
    ) u_tbl (
        .pclk(pclk),
        .presetn(presetn),
        .wr_en(mem_wr),
        .wr_idx(mem_a_idx),
        .wr_data(pwdata[`RTR_ADDR_MSB:`RTR_ADDR_LSB]),
        .rd_a_idx(mem_a_idx),
        .rd_a_data(mem_a_data),
        .rd_b_idx(mem_b_idx),
        .rd_b_data(mem_b_data)
    );

    // apb answer: one wait cycle, then data from the rdata register
    assign pready = answer;
    assign pslverr = answer && !mapped;
    assign prdata = s.rdata;

    // forward with the stored real address
    assign fwd_addr = s.hit ? mem_b_data : 7'h00;
    // zero real address blocks the target even with a live alias
    assign fwd_valid = s.hit && (mem_b_data != `RTR_TGT_RESET);
    assign fwd_block = s.look && !fwd_valid;

endmodule

// File: tb/rtr_remap_assertions.sv
// checker of the remap block's apb and lookup ports
`timescale 1ns/10ps
module rtr_remap_chk (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // apb
    input wire logic psel,
    input wire logic penable,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // lookup
    input wire logic lookup_valid,
    input wire logic [6:0] lookup_addr,
    input wire logic fwd_valid,
    input wire logic fwd_block,
    input wire logic [6:0] fwd_addr
);
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);
    a_ready_one_wait: assert property (
        $rose(penable) && psel |-> !pready ##1 pready) else $error("late");
    a_ready_in_access: assert property (
        pready |-> psel && penable) else $error("stray answer");
    a_err_no_data: assert property (
        pslverr |-> pready && prdata == 0) else $error("bad refusal");
    a_lookup_answered: assert property (
        lookup_valid |=> fwd_valid != fwd_block) else $error("no answer");
    a_answer_caused: assert property (
        fwd_valid || fwd_block |-> $past(lookup_valid)) else $error("stray");
    a_fwd_nonzero: assert property (
        fwd_valid |-> fwd_addr != 0) else $error("zero forwarded");
    a_block_no_addr: assert property (
        fwd_block |-> fwd_addr == 0) else $error("blocked with address");
    a_zero_alias: assert property (
        lookup_valid && lookup_addr == 0 |=> fwd_block) else $error("alias 0");
    // main scenarios reached
    cover property (fwd_valid);
    cover property (fwd_block);
    cover property (pslverr);
endmodule
bind rtr_remap rtr_remap_chk u_chk (.pclk, .presetn, .psel, .penable,
    .prdata, .pready, .pslverr, .lookup_valid, .lookup_addr, .fwd_valid,
    .fwd_block, .fwd_addr);

// File: tb/rtr_i2c_ctrl_model.sv
// local i2c controller model issuing address lookups
`timescale 1ns/10ps
module rtr_i2c_ctrl_model (
    // clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // request from the bench
    input wire logic req,
    input wire logic [6:0] req_addr,
    input wire logic req_port,
    // lookup toward the remap block
    output logic lookup_valid,
    output logic [6:0] lookup_addr,
    output logic lookup_port
);
    // idle address toggles so a stale value never looks valid
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            lookup_valid <= 1'b0;
            lookup_addr <= 7'h00;
            lookup_port <= 1'b0;
        end else begin
            lookup_valid <= req;
            lookup_addr <= req ? req_addr : ~lookup_addr;
            lookup_port <= req ? req_port : ~lookup_port;
        end
    end
endmodule

// File: tb/tb_top.sv
// self-checking bench of the target remap block
`timescale 1ns/10ps
module tb_top;
    logic pclk, presetn, psel, penable, pwrite, pready, pslverr, err;
    logic lookup_valid, lookup_port, fwd_valid, fwd_block, req, req_port;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, seed, rd, d, st_exp;
    logic [6:0] lookup_addr, fwd_addr, req_addr;
    logic [6:0] tgt [2][6];
    logic [6:0] als [2][6];
    int mismatches, checks_done;
    rtr_remap uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr,
        .pwdata, .prdata, .pready, .pslverr, .lookup_valid, .lookup_addr,
        .lookup_port, .fwd_valid, .fwd_block, .fwd_addr);
    rtr_i2c_ctrl_model ctl (.pclk, .presetn, .req, .req_addr, .req_port,
        .lookup_valid, .lookup_addr, .lookup_port);
    // 40 mhz clock
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    function automatic logic [11:0] ta(input int n);
        return 12'h1C0 + 12'(4 * n);
    endfunction
    task automatic chk(input logic [31:0] got, exp, input string m);
        checks_done++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: %s %h/%h", $time, m, got, exp);
        end
    endtask
    task automatic print_verdict();
        $display("checks %0d mismatches %0d", checks_done, mismatches);
        if (mismatches == 0 && checks_done > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask
    // one apb transfer, held until pready is seen
    task automatic apb(input logic w, input logic [11:0] a,
        input logic [31:0] v);
        int n;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= v;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        // pready, data and refusal all taken at the same rising edge
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 20);
        if (n >= 20) begin
            mismatches++;
            print_verdict();
        end
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    // lookup via the controller model; lowest matching slot wins
    task automatic look(input logic [6:0] a, input logic p);
        logic [8:0] e;
        logic [2:0] sl;
        e = 9'h080;
        sl = 3'd0;
        for (int i = 5; i >= 0; i--) begin
            if (als[p][i] != 0 && als[p][i] == a) begin
                e = (tgt[p][i] != 0) ? {2'b10, tgt[p][i]} : 9'h080;
                sl = 3'(i);
            end
        end
        // status word expected once the answer has been kept
        st_exp = {18'h0, e[6:0], p, sl, e[7], e[8], 1'b0};
        @(posedge pclk);
        req <= 1'b1;
        req_addr <= a;
        req_port <= p;
        @(posedge pclk);
        req <= 1'b0;
        @(posedge pclk);
        #1;
        chk({fwd_valid, fwd_block, fwd_addr}, e, "lookup");
    endtask
    initial begin
        {psel, penable, pwrite, presetn, req, req_port} = 6'h00;
        {paddr, pwdata, req_addr} = '0;
        seed = 32'h9a78_5379;
        tgt = '{default: '0};
        als = '{default: '0};
        repeat (2) @(posedge pclk);
        presetn <= 1'b1;
        // reset values of both copies, all blocked
        for (int p = 0; p < 2; p++) begin
            apb(1'b1, 12'h1F8, 32'(p));
            for (int n = 0; n < 6; n++) begin
                apb(1'b0, ta(n), 32'h0000_0000);
                chk(rd, 32'h0000_0000, "reset");
            end
            look(7'h2A, p[0]);
        end
        $display("test reset done");
        // random programming; slot 3 target left empty
        for (int p = 0; p < 2; p++) begin
            apb(1'b1, 12'h1F8, 32'(p));
            for (int n = 0; n < 6; n++) begin
                d = rnd();
                if (n == 2) d[7:1] = 7'h00;
                tgt[p][n] = d[7:1];
                als[p][n] = {d[14:12], 4'(n + 1)};
                apb(1'b1, ta(n), d);
                apb(1'b1, ta(n) + 12'h01C, {d[31:8], als[p][n], d[0]});
            end
        end
        // readback per port, then lookups incl. the other port
        for (int p = 0; p < 2; p++) begin
            apb(1'b1, 12'h1F8, 32'(p));
            apb(1'b0, 12'h1F8, 32'h0000_0000);
            chk(rd, 32'(p), "port select");
            for (int n = 0; n < 6; n++) begin
                apb(1'b0, ta(n), 32'h0000_0000);
                chk(rd, {24'h0, tgt[p][n], 1'b0}, "target");
                apb(1'b0, ta(n) + 12'h01C, 32'h0000_0000);
                chk(rd, {24'h0, als[p][n], 1'b0}, "alias");
                look(als[p][n], p[0]);
                apb(1'b0, 12'h1FC, 32'h0000_0000);
                chk(rd, st_exp, "status");
                look(als[p][n], !p[0]);
            end
            look(7'h70, p[0]);
        end
        $display("test remap done");
        // alias zero disables slot 1 of port 0
        apb(1'b1, 12'h1F8, 32'h0000_0000);
        d[6:0] = als[0][0];
        als[0][0] = 7'h00;
        apb(1'b1, 12'h1DC, 32'h0000_0000);
        look(7'h00, 1'b0);
        look(d[6:0], 1'b0);
        // unmapped and misaligned places are refused
        apb(1'b0, 12'h1D8, 32'h0000_0000);
        chk({31'h0, err}, 32'h0000_0001, "unmapped");
        apb(1'b1, ta(0) + 12'h002, 32'hFFFF_FFFF);
        chk({31'h0, err}, 32'h0000_0001, "misaligned");
        // random lookups
        repeat (30) begin
            d = rnd();
            look(d[6:0], d[7]);
        end
        apb(1'b0, 12'h1FC, 32'h0000_0000);
        chk(rd, st_exp, "status random");
        $display("test refusal and random done");
        print_verdict();
    end
endmodule
